// >>> design/adc_result_pkg.sv
// Constants, field layout and helpers shared by the converter result logic
package adc_result_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FILT_L = 8'h04;
  localparam logic [7:0] OFF_FILT_H = 8'h08;
  localparam logic [7:0] OFF_RES_H = 8'h0c;
  localparam logic [7:0] OFF_RES_L = 8'h10;
  localparam logic [7:0] OFF_PREV_H = 8'h14;
  localparam logic [7:0] OFF_PREV_L = 8'h18;
  localparam logic [7:0] OFF_ACC_H = 8'h1c;
  localparam logic [7:0] OFF_ACC_L = 8'h20;
  localparam logic [7:0] OFF_STPT_H = 8'h24;
  localparam logic [7:0] OFF_STPT_L = 8'h28;

  // ----------------------------------------------------------------
  // Control word field positions and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_JUSTIFY_BIT = 0;
  localparam int CTRL_PSRC_BIT = 1;
  localparam int CTRL_SHIFT_LSB = 2;
  localparam int CTRL_SHIFT_W = 3;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_CALC_LSB = 8;
  localparam int CTRL_CALC_W = 3;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  localparam int RES_W = 10;
  localparam int WORD_W = 16;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    MODE_BASIC = 3'h0,
    MODE_ACCUM = 3'h1,
    MODE_AVG = 3'h2,
    MODE_BURST = 3'h3,
    MODE_LPF = 3'h4
  } compute_mode_e;

  // ----------------------------------------------------------------
  // Result layout helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pack_high(input logic [RES_W-1:0] res, input logic right);
    pack_high = right ? {6'h00, res[9:8]} : res[9:2];
  endfunction : pack_high

  function automatic logic [7:0] pack_low(input logic [RES_W-1:0] res, input logic right);
    pack_low = right ? res[7:0] : {res[1:0], 6'h00};
  endfunction : pack_low

  function automatic logic [WORD_W-1:0] shift_signed(input logic [WORD_W-1:0] v,
                                                     input logic [CTRL_SHIFT_W-1:0] n);
    shift_signed = WORD_W'($signed(v) >>> n);
  endfunction : shift_signed

endpackage : adc_result_pkg

// >>> design/adc_filter_unit.sv
// Filter output stage: shifted accumulator or low-pass filter state
`timescale 1ns/10ps
module adc_filter_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lpf_mode,
  input wire logic [adc_result_pkg::CTRL_SHIFT_W-1:0] shift,
  input wire logic [adc_result_pkg::WORD_W-1:0] acc,
  input wire logic sample_valid,
  input wire logic [adc_result_pkg::RES_W-1:0] sample,
  output logic [adc_result_pkg::WORD_W-1:0] filter_value
);

  logic [adc_result_pkg::WORD_W-1:0] lpf_reg;
  logic [16:0] diff;

  // Difference kept one bit wider so a falling input cannot wrap
  assign diff = {1'b0, 6'h00, sample} - {lpf_reg[15], lpf_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpf_reg <= adc_result_pkg::WORD_RESET;
    end else if (sample_valid && lpf_mode) begin
      lpf_reg <= lpf_reg + 16'($signed(diff) >>> shift);
    end
  end

  // Registered view; lags the shifted accumulator, or the low-pass state in low-pass mode, by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_value <= adc_result_pkg::WORD_RESET;
    end else if (lpf_mode) begin
      filter_value <= lpf_reg;
    end else begin
      filter_value <= adc_result_pkg::shift_signed(acc, shift);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_filter_shifted: assert property ($past(aresetn) && !$past(lpf_mode) |->
    filter_value == adc_result_pkg::shift_signed($past(acc), $past(shift)))
    else $error("filter output is not the shifted accumulator");

  chk_filter_lpf: assert property ($past(aresetn) && $past(lpf_mode) |->
    filter_value == $past(lpf_reg))
    else $error("filter output is not the low-pass state");

endmodule : adc_filter_unit

// >>> design/adc_result_compute_regs.sv
// Result, previous, accumulator and setpoint registers behind an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module adc_result_compute_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [adc_result_pkg::RES_W-1:0] conv_data,
  output logic [adc_result_pkg::WORD_W-1:0] filter_output,
  output logic [adc_result_pkg::WORD_W-1:0] threshold_setpoint,
  output logic [adc_result_pkg::CTRL_CALC_W-1:0] error_calc_select
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [adc_result_pkg::CTRL_W-1:0] ctrl_reg;
  logic [adc_result_pkg::RES_W-1:0] res_reg;
  logic [adc_result_pkg::WORD_W-1:0] prev_reg;
  logic [adc_result_pkg::WORD_W-1:0] acc_reg;
  logic [adc_result_pkg::WORD_W-1:0] acc_next;
  logic [adc_result_pkg::WORD_W-1:0] filter_value;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic do_write;
  logic wr_lane0;
  logic justify_select;
  logic previous_source_select;
  logic [adc_result_pkg::CTRL_SHIFT_W-1:0] result_shift_count;
  adc_result_pkg::compute_mode_e mode;
  logic lpf_mode;
  logic acc_mode;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign justify_select = ctrl_reg[adc_result_pkg::CTRL_JUSTIFY_BIT];
  assign previous_source_select = ctrl_reg[adc_result_pkg::CTRL_PSRC_BIT];
  assign result_shift_count = ctrl_reg[adc_result_pkg::CTRL_SHIFT_LSB +:
                                       adc_result_pkg::CTRL_SHIFT_W];
  assign mode = adc_result_pkg::compute_mode_e'(ctrl_reg[adc_result_pkg::CTRL_MODE_LSB +:
                                                         adc_result_pkg::CTRL_MODE_W]);
  assign lpf_mode = (mode == adc_result_pkg::MODE_LPF);
  assign acc_mode = (mode == adc_result_pkg::MODE_ACCUM) || (mode == adc_result_pkg::MODE_AVG) ||
                    (mode == adc_result_pkg::MODE_BURST);

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Address and data are held independently; the write fires once both are in
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane0 = do_write && w_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      s_axi_awready <= !aw_held_reg && !s_axi_bvalid && !s_axi_awready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (do_write) begin
        w_held_reg <= 1'b0;
      end
      s_axi_wready <= !w_held_reg && !s_axi_bvalid && !s_axi_wready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adc_result_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok(aw_addr_reg) ? adc_result_pkg::RESP_OKAY :
                     adc_result_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= adc_result_pkg::OFF_STPT_L) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = wr_lane0 && (aw_addr_reg == a);
  endfunction : wr_at

  // ----------------------------------------------------------------
  // Control and setpoint
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= adc_result_pkg::CTRL_RESET;
    end else if (do_write && aw_addr_reg == adc_result_pkg::OFF_CTRL) begin
      if (w_strb_reg[0]) begin
        ctrl_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        ctrl_reg[10:8] <= w_data_reg[10:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_setpoint <= adc_result_pkg::WORD_RESET;
    end else if (wr_at(adc_result_pkg::OFF_STPT_H)) begin
      threshold_setpoint[15:8] <= w_data_reg[7:0];
    end else if (wr_at(adc_result_pkg::OFF_STPT_L)) begin
      threshold_setpoint[7:0] <= w_data_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_calc_select <= 3'h0;
    end else begin
      error_calc_select <= ctrl_reg[adc_result_pkg::CTRL_CALC_LSB +:
                                    adc_result_pkg::CTRL_CALC_W];
    end
  end

  // ----------------------------------------------------------------
  // Conversion result, kept unjustified
  // ----------------------------------------------------------------
  // A finishing conversion wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_reg <= adc_result_pkg::RES_RESET;
    end else if (conv_done) begin
      res_reg <= conv_data;
    end else if (wr_at(adc_result_pkg::OFF_RES_H)) begin
      if (justify_select) begin
        res_reg[9:8] <= w_data_reg[1:0];
      end else begin
        res_reg[9:2] <= w_data_reg[7:0];
      end
    end else if (wr_at(adc_result_pkg::OFF_RES_L)) begin
      if (justify_select) begin
        res_reg[7:0] <= w_data_reg[7:0];
      end else begin
        res_reg[1:0] <= w_data_reg[7:6];
      end
    end
  end

  // ----------------------------------------------------------------
  // Previous result capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= adc_result_pkg::WORD_RESET;
    end else if (conv_start) begin
      if (previous_source_select) begin
        prev_reg <= filter_value;
      end else begin
        prev_reg <= {adc_result_pkg::pack_high(res_reg, justify_select),
                     adc_result_pkg::pack_low(res_reg, justify_select)};
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Low-pass mode feeds back the filter so the sum tracks input minus output
  always_comb begin
    acc_next = acc_reg;
    if (acc_mode) begin
      acc_next = acc_reg + {6'h00, conv_data};
    end else if (lpf_mode) begin
      acc_next = acc_reg + {6'h00, conv_data} - filter_value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= adc_result_pkg::WORD_RESET;
    end else if (conv_done) begin
      acc_reg <= acc_next;
    end else if (wr_at(adc_result_pkg::OFF_ACC_H)) begin
      acc_reg[15:8] <= w_data_reg[7:0];
    end else if (wr_at(adc_result_pkg::OFF_ACC_L)) begin
      acc_reg[7:0] <= w_data_reg[7:0];
    end
  end

  adc_filter_unit filter_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .lpf_mode(lpf_mode),
    .shift(result_shift_count),
    .acc(acc_reg),
    .sample_valid(conv_done),
    .sample(conv_data),
    .filter_value(filter_value)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_output <= adc_result_pkg::WORD_RESET;
    end else begin
      filter_output <= filter_value;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      adc_result_pkg::OFF_CTRL: rd_byte = ctrl_reg[7:0];
      adc_result_pkg::OFF_FILT_L: rd_byte = filter_value[7:0];
      adc_result_pkg::OFF_FILT_H: rd_byte = filter_value[15:8];
      adc_result_pkg::OFF_RES_H: rd_byte = adc_result_pkg::pack_high(res_reg, justify_select);
      adc_result_pkg::OFF_RES_L: rd_byte = adc_result_pkg::pack_low(res_reg, justify_select);
      adc_result_pkg::OFF_PREV_H: rd_byte = prev_reg[15:8];
      adc_result_pkg::OFF_PREV_L: rd_byte = prev_reg[7:0];
      adc_result_pkg::OFF_ACC_H: rd_byte = acc_reg[15:8];
      adc_result_pkg::OFF_ACC_L: rd_byte = acc_reg[7:0];
      adc_result_pkg::OFF_STPT_H: rd_byte = threshold_setpoint[15:8];
      adc_result_pkg::OFF_STPT_L: rd_byte = threshold_setpoint[7:0];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adc_result_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= (s_axi_araddr == adc_result_pkg::OFF_CTRL) ?
                     {21'h000000, ctrl_reg} : {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? adc_result_pkg::RESP_OKAY : adc_result_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rd_req(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  chk_res_high_left: assert property (rd_req(adc_result_pkg::OFF_RES_H) ##0 !justify_select
    |=> s_axi_rdata == {24'h000000, $past(res_reg[9:2])})
    else $error("left-justified high byte wrong");

  chk_res_low_left: assert property (rd_req(adc_result_pkg::OFF_RES_L) ##0 !justify_select
    |=> s_axi_rdata == {24'h000000, $past(res_reg[1:0]), 6'h00})
    else $error("left-justified low byte wrong");

  chk_res_high_right: assert property (rd_req(adc_result_pkg::OFF_RES_H) ##0 justify_select
    |=> s_axi_rdata == {30'h00000000, $past(res_reg[9:8])})
    else $error("right-justified high byte wrong");

  chk_res_low_right: assert property (rd_req(adc_result_pkg::OFF_RES_L) ##0 justify_select
    |=> s_axi_rdata == {24'h000000, $past(res_reg[7:0])})
    else $error("right-justified low byte wrong");

  chk_prev_filter: assert property (conv_start && previous_source_select
    |=> prev_reg == $past(filter_value))
    else $error("previous value did not take the filter output");

  chk_prev_result: assert property (conv_start && !previous_source_select
    |=> prev_reg == {adc_result_pkg::pack_high($past(res_reg), $past(justify_select)),
                     adc_result_pkg::pack_low($past(res_reg), $past(justify_select))})
    else $error("previous value did not take the justified result");

  chk_acc_sum: assert property (conv_done && acc_mode
    |=> acc_reg == 16'($past(acc_reg) + {6'h00, $past(conv_data)}))
    else $error("accumulator did not add the sample");

  chk_stpt_write: assert property (
    wr_lane0 && aw_addr_reg == adc_result_pkg::OFF_STPT_L
    |=> threshold_setpoint[7:0] == $past(w_data_reg[7:0]) ##2 error_calc_select ==
        ctrl_reg[adc_result_pkg::CTRL_CALC_LSB +: adc_result_pkg::CTRL_CALC_W] || $changed(ctrl_reg))
    else $error("setpoint low byte not written");

  chk_layout_only: assert property (!conv_done && !(wr_lane0 &&
    (aw_addr_reg == adc_result_pkg::OFF_RES_H || aw_addr_reg == adc_result_pkg::OFF_RES_L))
    |=> $stable(res_reg))
    else $error("result changed without a conversion or write");

endmodule : adc_result_compute_regs

// >>> verif/adc_result_compute_regs_tb_top.sv
// Self-checking bench for the converter result registers over AXI4-Lite
`timescale 1ns/10ps
`define check(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module adc_result_compute_regs_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic conv_start = 1'b0;
  logic conv_done = 1'b0;
  logic [9:0] conv_data = 10'h000;
  logic [15:0] filter_output;
  logic [15:0] threshold_setpoint;
  logic [2:0] error_calc_select;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] fexp;

  adc_result_compute_regs i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_done, .conv_data,
    .filter_output, .threshold_setpoint, .error_calc_select
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Bus and converter drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `check(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    `check(s_axi_rdata, ed)
    `check(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
  endtask : rd

  // Control word: calc 10:8, mode 7:5, shift 4:2, source 1, justify 0
  task automatic ctrl(input logic [2:0] calc, input logic [2:0] mode,
                      input logic [2:0] sh, input logic ps, input logic j);
    wr(8'h00, {21'h0, calc, mode, sh, ps, j}, 4'h3, 2'b00);
    repeat (4) @(posedge aclk);
  endtask : ctrl

  task automatic pulse(input logic done, input logic [9:0] d);
    @(posedge aclk);
    conv_done <= done;
    conv_start <= ~done;
    conv_data <= d;
    @(posedge aclk);
    conv_done <= 1'b0;
    conv_start <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse

  function automatic logic [31:0] hi(input logic [9:0] r, input logic j);
    hi = j ? {30'h0, r[9:8]} : {24'h0, r[9:2]};
  endfunction : hi

  function automatic logic [31:0] lo(input logic [9:0] r, input logic j);
    lo = j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00};
  endfunction : lo

  task automatic report_and_stop;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // A hang ends the run after far more cycles than the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h1c, 32'h0, 2'b00);
    rd(8'h2c, 32'h0, 2'b10);
    wr(8'h2c, 32'h55, 4'h1, 2'b10);
    pulse(1'b1, 10'h2d7);
    rd(8'h0c, hi(10'h2d7, 1'b0), 2'b00);
    rd(8'h10, lo(10'h2d7, 1'b0), 2'b00);
    ctrl(3'h0, 3'h0, 3'h0, 1'b0, 1'b1);
    rd(8'h0c, hi(10'h2d7, 1'b1), 2'b00);
    rd(8'h10, lo(10'h2d7, 1'b1), 2'b00);
    wr(8'h10, 32'h3e, 4'h1, 2'b00);
    rd(8'h10, 32'h3e, 2'b00);
    pulse(1'b0, 10'h000);
    rd(8'h14, hi(10'h23e, 1'b1), 2'b00);
    rd(8'h18, lo(10'h23e, 1'b1), 2'b00);
    ctrl(3'h0, 3'h0, 3'h0, 1'b0, 1'b0);
    rd(8'h0c, hi(10'h23e, 1'b0), 2'b00);
    rd(8'h10, lo(10'h23e, 1'b0), 2'b00);
    pulse(1'b0, 10'h000);
    rd(8'h14, hi(10'h23e, 1'b0), 2'b00);
    rd(8'h18, lo(10'h23e, 1'b0), 2'b00);
    // Negative accumulator so the shift has to carry the sign down
    wr(8'h1c, 32'h80, 4'h1, 2'b00);
    wr(8'h20, 32'h40, 4'h1, 2'b00);
    rd(8'h1c, 32'h80, 2'b00);
    rd(8'h20, 32'h40, 2'b00);
    for (int m = 1; m <= 3; m++) begin
      ctrl(3'h0, 3'(m), 3'(2 * m + 1), 1'b1, 1'b0);
      fexp = 16'($signed(16'h8040) >>> (2 * m + 1));
      `check(filter_output, fexp)
      rd(8'h04, {24'h0, fexp[7:0]}, 2'b00);
      rd(8'h08, {24'h0, fexp[15:8]}, 2'b00);
    end
    ctrl(3'h0, 3'h1, 3'h3, 1'b1, 1'b0);
    fexp = 16'($signed(16'h8040) >>> 3);
    pulse(1'b0, 10'h000);
    rd(8'h14, {24'h0, fexp[15:8]}, 2'b00);
    rd(8'h18, {24'h0, fexp[7:0]}, 2'b00);
    wr(8'h04, 32'h55, 4'h1, 2'b00);
    rd(8'h04, {24'h0, fexp[7:0]}, 2'b00);
    pulse(1'b1, 10'h3ff);
    rd(8'h1c, 32'h84, 2'b00);
    rd(8'h20, 32'h3f, 2'b00);
    fexp = 16'($signed(16'h843f) >>> 3);
    `check(filter_output, fexp)
    // With no shift the low-pass state jumps straight to the sample
    ctrl(3'h0, 3'h4, 3'h0, 1'b1, 1'b0);
    pulse(1'b1, 10'h155);
    `check(filter_output, 16'h0155)
    rd(8'h04, 32'h55, 2'b00);
    rd(8'h08, 32'h01, 2'b00);
    wr(8'h24, 32'ha5, 4'h1, 2'b00);
    wr(8'h28, 32'h3c, 4'h1, 2'b00);
    wr(8'h28, 32'hff, 4'h0, 2'b00);
    rd(8'h24, 32'ha5, 2'b00);
    rd(8'h28, 32'h3c, 2'b00);
    ctrl(3'h5, 3'h0, 3'h0, 1'b0, 1'b0);
    `check(threshold_setpoint, 16'ha53c)
    `check(error_calc_select, 3'h5)
    // Software writes land through the justify layout in force
    wr(8'h0c, 32'h5a, 4'h1, 2'b00);
    wr(8'h10, 32'hff, 4'h1, 2'b00);
    rd(8'h0c, hi(10'h16b, 1'b0), 2'b00);
    rd(8'h10, lo(10'h16b, 1'b0), 2'b00);
    ctrl(3'h0, 3'h0, 3'h0, 1'b0, 1'b1);
    wr(8'h0c, 32'h02, 4'h1, 2'b00);
    rd(8'h0c, hi(10'h26b, 1'b1), 2'b00);
    rd(8'h10, lo(10'h26b, 1'b1), 2'b00);
    report_and_stop();
  end
endmodule : adc_result_compute_regs_tb_top
